// ===== src/iho_consts.svh
`ifndef IHO_CONSTS_SVH
`define IHO_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IHO_OFS_CHIP_IDENTITY 8'h50
`define IHO_OFS_IRQ_CFG 8'h54
`define IHO_OFS_INTERRUPT_STATUS 8'h58
`define IHO_OFS_INT_EN 8'h5C
`define IHO_ADDR_W 8
`define IHO_DATA_W 32

// ----------------------------------------------------------------------
// interrupt_output_config fields
// ----------------------------------------------------------------------
`define IHO_CFG_INTERVAL_HI 31
`define IHO_CFG_INTERVAL_LO 24
`define IHO_CFG_RESTART 14
`define IHO_CFG_ACTIVE 13
`define IHO_CFG_MASTER 12
`define IHO_CFG_ENABLE 8
`define IHO_CFG_POLARITY 4
`define IHO_CFG_TYPE 0
`define IHO_INTERVAL_W 8

// ----------------------------------------------------------------------
// interrupt sources and reset values
// ----------------------------------------------------------------------
`define IHO_PME_BIT 17
`define IHO_RESET_WORD 32'h0000_0000
`define IHO_INTERVAL_ZERO 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IHO_CLK_PERIOD_NS 40
`define IHO_TICK_PERIOD_NS 10000
`define IHO_TICK_CYCLES (`IHO_TICK_PERIOD_NS / `IHO_CLK_PERIOD_NS)

`endif

// ===== src/iho_pkg.sv
`default_nettype none
package iho_pkg;

   // hold-off controller states, one-hot
   typedef enum logic [1:0] {
      IHO_ST_PASS = 2'b01,
      IHO_ST_HOLD = 2'b10
   } iho_state_e;

   typedef logic [7:0] iho_interval_t;

endpackage

`default_nettype wire

// ===== src/iho_tick.sv
`timescale 1ns/10ps
`default_nettype none
`include "iho_consts.svh"

module iho_tick #(
   parameter int TICK_CYCLES = `IHO_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clr,
   output logic tick_q
);

   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic tick_d;

   // free divider, realigned by clr so a fresh interval starts whole
   always_comb begin
      cnt_d = cnt_q + CW'(1);
      tick_d = 1'b0;
      if (clr) begin
         cnt_d = '0;
      end else if (cnt_q == LAST) begin
         cnt_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

endmodule

`default_nettype wire

// ===== src/iho_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "iho_consts.svh"

// Summary of operation
// - The pin is held off for interval field bits 31:24 times 10 us.
// - Writing zero to the interval ends any hold-off, clears the counter and lets pending irqs out.
// - A new non-zero interval governs every interrupt except the power management event that follows it.
// - The power management event source bypasses the hold-off entirely.
// - Writing one to bit 14 clears the counter and starts a fresh hold-off; the bit reads zero.
// - Bit 13 reads one while a hold-off keeps interrupts from the pin.
// - Bit 12 shows the internal combined interrupt line regardless of enable or hold-off.
// - With enable bit 8 clear the pin stays deasserted; status bits are untouched.
// - Polarity bit 4 picks active low (0) or active high (1) in push-pull mode.
// - Bit 0 picks open-drain (0, always active low) or push-pull (1).
// - Polarity and driver type survive a soft reset; only system reset clears them.
// - The identity register returns chip id high and revision low, read-only.
// - Config at 54h, status at 58h, enable at 5Ch, each reset to zero.

module iho_top
   import iho_pkg::*;
#(
   parameter logic [15:0] CHIP_ID = 16'hC0DE, // arbitrary value
   parameter logic [15:0] CHIP_REV = 16'h0001, // arbitrary value
   parameter int TICK_CYCLES = `IHO_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic [31:0] int_src_set,
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [`IHO_ADDR_W-1:0] host_addr,
   input wire logic [`IHO_DATA_W-1:0] host_data_in,
   output logic [`IHO_DATA_W-1:0] host_data_out_q,
   output logic host_data_oe_q,
   output logic irq_pin_out_q,
   output logic irq_pin_oe_q
);

   // ----------------------------------------------------------------------
   // host strobe synchronisers
   // ----------------------------------------------------------------------
   logic [2:0] cs_sync_q, rd_sync_q, wr_sync_q;
   logic cs_act, rd_act, wr_act;
   logic wr_seen_q, wr_seen_d;
   logic wr_stb;
   logic [2:0] cs_sync_d, rd_sync_d, wr_sync_d;

   // a level counts once stages two and three agree
   always_comb begin
      cs_sync_d = {cs_sync_q[1:0], ~host_cs_n};
      rd_sync_d = {rd_sync_q[1:0], ~host_rd_n};
      wr_sync_d = {wr_sync_q[1:0], ~host_wr_n};
      cs_act = cs_sync_q[1] & cs_sync_q[2];
      rd_act = rd_sync_q[1] & rd_sync_q[2] & cs_act;
      wr_act = wr_sync_q[1] & wr_sync_q[2] & cs_act;
      wr_stb = wr_act & ~wr_seen_q; // one write per strobe
      wr_seen_d = wr_act;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cs_sync_q <= 3'h0;
         rd_sync_q <= 3'h0;
         wr_sync_q <= 3'h0;
         wr_seen_q <= 1'b0;
      end else begin
         cs_sync_q <= cs_sync_d;
         rd_sync_q <= rd_sync_d;
         wr_sync_q <= wr_sync_d;
         wr_seen_q <= wr_seen_d;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [`IHO_ADDR_W-1:0] a,
                                input logic [`IHO_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   logic wr_cfg, wr_sts, wr_en;
   logic [31:0] sts_q, sts_d, en_q, en_d;
   iho_interval_t interval_q, interval_d;
   logic irq_enable_q, irq_enable_d;
   logic polarity_q, polarity_d, drv_type_q, drv_type_d;
   logic restart;
   logic soft_any;

   always_comb begin
      wr_cfg = wr_stb & hit(host_addr, `IHO_OFS_IRQ_CFG);
      wr_sts = wr_stb & hit(host_addr, `IHO_OFS_INTERRUPT_STATUS);
      wr_en = wr_stb & hit(host_addr, `IHO_OFS_INT_EN);
      restart = wr_cfg & host_data_in[`IHO_CFG_RESTART];
      soft_any = soft_rst;
      // set wins over the write-one clear
      sts_d = (sts_q & ~(wr_sts ? host_data_in : `IHO_RESET_WORD)) | int_src_set;
      en_d = wr_en ? host_data_in : en_q;
      interval_d = wr_cfg ? host_data_in[`IHO_CFG_INTERVAL_HI:`IHO_CFG_INTERVAL_LO]
                          : interval_q;
      irq_enable_d = wr_cfg ? host_data_in[`IHO_CFG_ENABLE] : irq_enable_q;
      polarity_d = wr_cfg ? host_data_in[`IHO_CFG_POLARITY] : polarity_q;
      drv_type_d = wr_cfg ? host_data_in[`IHO_CFG_TYPE] : drv_type_q;
   end

   // soft reset spares polarity and driver type
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         polarity_q <= 1'b0;
         drv_type_q <= 1'b0;
      end else begin
         polarity_q <= polarity_d;
         drv_type_q <= drv_type_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || soft_any) begin
         sts_q <= `IHO_RESET_WORD;
         en_q <= `IHO_RESET_WORD;
         interval_q <= `IHO_INTERVAL_ZERO;
         irq_enable_q <= 1'b0;
      end else begin
         sts_q <= sts_d;
         en_q <= en_d;
         interval_q <= interval_d;
         irq_enable_q <= irq_enable_d;
      end
   end

   // ----------------------------------------------------------------------
   // hold-off controller
   // ----------------------------------------------------------------------
   logic [31:0] pend;
   logic master_irq, pme_irq, gen_irq;
   logic tick;
   iho_state_e state_q, state_d;
   iho_interval_t hcnt_q, hcnt_d;
   logic assert_q, assert_d;
   logic tick_clr;

   always_comb begin
      pend = sts_q & en_q;
      master_irq = |pend;
      pme_irq = pend[`IHO_PME_BIT];
      gen_irq = |(pend & ~(32'h1 << `IHO_PME_BIT));
      state_d = state_q;
      hcnt_d = hcnt_q;
      tick_clr = 1'b0;
      case (state_q)
         IHO_ST_PASS: begin
            // the interval written with a restart governs that restart
            if (interval_d != `IHO_INTERVAL_ZERO && (restart || (assert_q && !gen_irq))) begin
               state_d = IHO_ST_HOLD;
               hcnt_d = `IHO_INTERVAL_ZERO;
               tick_clr = 1'b1;
            end
         end
         IHO_ST_HOLD: begin
            if (interval_q == `IHO_INTERVAL_ZERO) begin
               state_d = IHO_ST_PASS;
               hcnt_d = `IHO_INTERVAL_ZERO;
            end else if (restart) begin
               hcnt_d = `IHO_INTERVAL_ZERO;
               tick_clr = 1'b1;
            end else if (tick) begin
               hcnt_d = hcnt_q + 8'h01;
               if (hcnt_d >= interval_q) begin
                  state_d = IHO_ST_PASS;
                  hcnt_d = `IHO_INTERVAL_ZERO;
               end
            end
         end
         default: begin
            state_d = IHO_ST_PASS;
            hcnt_d = `IHO_INTERVAL_ZERO;
         end
      endcase
      // pme goes straight through; others wait out the hold-off
      assert_d = irq_enable_q & (pme_irq | (gen_irq & (state_d == IHO_ST_PASS)));
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || soft_any) begin
         state_q <= IHO_ST_PASS;
         hcnt_q <= `IHO_INTERVAL_ZERO;
         assert_q <= 1'b0;
      end else begin
         state_q <= state_d;
         hcnt_q <= hcnt_d;
         assert_q <= assert_d;
      end
   end

   iho_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clr(tick_clr),
      .tick_q(tick)
   );

   // ----------------------------------------------------------------------
   // pin driver and read data
   // ----------------------------------------------------------------------
   logic pin_out_d, pin_oe_d;
   logic [31:0] rdata;
   logic [31:0] cfg_word;

   always_comb begin
      if (drv_type_q) begin
         pin_oe_d = 1'b1;
         pin_out_d = polarity_q ? assert_d : ~assert_d;
      end else begin
         pin_oe_d = assert_d;
         pin_out_d = 1'b0;
      end
      cfg_word = `IHO_RESET_WORD;
      cfg_word[`IHO_CFG_INTERVAL_HI:`IHO_CFG_INTERVAL_LO] = interval_q;
      cfg_word[`IHO_CFG_ACTIVE] = (state_q == IHO_ST_HOLD);
      cfg_word[`IHO_CFG_MASTER] = master_irq;
      cfg_word[`IHO_CFG_ENABLE] = irq_enable_q;
      cfg_word[`IHO_CFG_POLARITY] = polarity_q;
      cfg_word[`IHO_CFG_TYPE] = drv_type_q;
      if (hit(host_addr, `IHO_OFS_CHIP_IDENTITY)) begin
         rdata = {CHIP_ID, CHIP_REV};
      end else if (hit(host_addr, `IHO_OFS_IRQ_CFG)) begin
         rdata = cfg_word;
      end else if (hit(host_addr, `IHO_OFS_INTERRUPT_STATUS)) begin
         rdata = sts_q;
      end else if (hit(host_addr, `IHO_OFS_INT_EN)) begin
         rdata = en_q;
      end else begin
         rdata = `IHO_RESET_WORD; // unmapped reads zero
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_pin_out_q <= 1'b1;
         irq_pin_oe_q <= 1'b0;
         host_data_out_q <= `IHO_RESET_WORD;
         host_data_oe_q <= 1'b0;
      end else begin
         irq_pin_out_q <= pin_out_d;
         irq_pin_oe_q <= pin_oe_d;
         host_data_out_q <= rdata;
         host_data_oe_q <= rd_act;
      end
   end

endmodule

`default_nettype wire

// ===== test/iho_properties.sv
`timescale 1ns/10ps
`default_nettype none
module iho_properties
   import iho_pkg::*;
#(
   parameter logic [15:0] CHIP_ID = 16'hC0DE, // arbitrary value
   parameter logic [15:0] CHIP_REV = 16'h0001, // arbitrary value
   parameter int TICK_CYCLES = 250
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic [31:0] int_src_set,
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [7:0] host_addr,
   input wire logic [31:0] host_data_in,
   input wire logic [31:0] host_data_out_q,
   input wire logic host_data_oe_q,
   input wire logic irq_pin_out_q,
   input wire logic irq_pin_oe_q
);
   logic cfg_wr;
   logic ty_q, pol_q, en_q;
   logic [2:0] age_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   assign cfg_wr = !host_cs_n && !host_wr_n && host_addr == 8'h54;
   // shadow of the pin config bits, age counts settled cycles
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         {ty_q, pol_q, en_q, age_q} <= 6'h00;
      end else begin
         if (cfg_wr) begin
            {ty_q, pol_q, en_q} <= {host_data_in[0], host_data_in[4], host_data_in[8]};
         end
         if (soft_rst) en_q <= 1'b0;
         age_q <= (cfg_wr || soft_rst) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
      end
   end
   sequence rd_go;
      $fell(host_rd_n) && !host_cs_n;
   endsequence
   sequence rd_idle;
      host_rd_n [*5];
   endsequence
   a_rst_pin_idle: assert property (
      $fell(sys_rst) |-> !irq_pin_oe_q && irq_pin_out_q && !host_data_oe_q)
      else $error("outputs active after reset");
   a_rd_answer: assert property (rd_go |-> ##[3:4] host_data_oe_q)
      else $error("read not answered");
   a_rd_release: assert property ($rose(host_rd_n) |-> ##[2:3] !host_data_oe_q)
      else $error("read drive not released");
   a_rd_idle_quiet: assert property (rd_idle |-> !host_data_oe_q)
      else $error("data driven without read");
   a_id_value: assert property (
      host_data_oe_q && host_addr == 8'h50 |-> host_data_out_q == {CHIP_ID, CHIP_REV})
      else $error("identity value wrong");
   a_unmapped_zero: assert property (host_data_oe_q &&
      !(host_addr inside {8'h50, 8'h54, 8'h58, 8'h5C}) |-> host_data_out_q == 32'h0)
      else $error("unmapped read not zero");
   a_restart_reads_zero: assert property (
      host_data_oe_q && host_addr == 8'h54 |-> !host_data_out_q[14])
      else $error("restart bit reads one");
   a_push_pull_drives: assert property (age_q == 3'h7 && ty_q |-> irq_pin_oe_q)
      else $error("push-pull pin not driven");
   a_od_low: assert property (
      age_q == 3'h7 && !ty_q && irq_pin_oe_q |-> !irq_pin_out_q)
      else $error("open-drain pin driven high");
   a_off_pin_quiet: assert property (age_q == 3'h7 && !en_q |->
      (ty_q ? irq_pin_out_q == !pol_q : !irq_pin_oe_q))
      else $error("disabled pin asserted");
endmodule
bind iho_top iho_properties #(.CHIP_ID(CHIP_ID), .CHIP_REV(CHIP_REV),
   .TICK_CYCLES(TICK_CYCLES)) u_props (.sys_clk, .sys_rst, .soft_rst, .int_src_set,
   .host_cs_n, .host_rd_n, .host_wr_n, .host_addr, .host_data_in, .host_data_out_q,
   .host_data_oe_q, .irq_pin_out_q, .irq_pin_oe_q);
`default_nettype wire

// ===== test/iho_host.sv
`timescale 1ns/10ps
`default_nettype none
module iho_host (
   input wire logic sys_clk,
   input wire logic [31:0] host_data_out_q,
   input wire logic host_data_oe_q,
   output logic host_cs_n,
   output logic host_rd_n,
   output logic host_wr_n,
   output logic [7:0] host_addr,
   output logic [31:0] host_data_in
);
   initial begin
      {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
      {host_addr, host_data_in} = 40'h0;
   end
   // gap between accesses, released lines stop showing old values
   task automatic idle();
      repeat (4) @(posedge sys_clk);
      host_addr <= ~host_addr;
      host_data_in <= ~host_data_in;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {host_addr, host_data_in, host_cs_n, host_wr_n} <= {a, d, 2'b00};
      repeat (4) @(posedge sys_clk);
      {host_cs_n, host_wr_n} <= 2'b11;
      idle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge sys_clk);
      {host_addr, host_cs_n, host_rd_n} <= {a, 2'b00};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (host_data_oe_q !== 1'b1 && n < 20);
      // a read that never got its answer hands back unknowns
      d = (host_data_oe_q === 1'b1) ? host_data_out_q : 32'hXXXX_XXXX;
      {host_cs_n, host_rd_n} <= 2'b11;
      idle();
   endtask
endmodule
`default_nettype wire

// ===== test/irq_output_holdoff_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module irq_output_holdoff_control_tb;
   localparam logic [31:0] ID = 32'hA5A5_0003; // arbitrary value
   logic sys_clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0;
   logic [31:0] int_src_set = 32'h0, rdat, host_data_in, host_data_out_q;
   logic host_cs_n, host_rd_n, host_wr_n, host_data_oe_q, irq_pin_out_q, irq_pin_oe_q;
   logic [7:0] host_addr;
   logic [7:0] ofs [4] = '{8'h54, 8'h58, 8'h5C, 8'h60};
   int err_count = 0, n_tests = 0, t, n;
   always #20 sys_clk = ~sys_clk;
   iho_top #(.CHIP_ID(ID[31:16]), .CHIP_REV(ID[15:0]), .TICK_CYCLES(4)) uut (.sys_clk,
      .sys_rst, .soft_rst, .int_src_set, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr,
      .host_data_in, .host_data_out_q, .host_data_oe_q, .irq_pin_out_q, .irq_pin_oe_q);
   iho_host host (.sys_clk, .host_data_out_q, .host_data_oe_q, .host_cs_n, .host_rd_n,
      .host_wr_n, .host_addr, .host_data_in);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      host.rd(a, rdat);
      chk(rdat & m, e);
   endtask
   // pin as {drive enable, level}, looked at mid-cycle once settled
   task automatic pin_is(input logic [1:0] e);
      @(negedge sys_clk);
      chk({30'h0, irq_pin_oe_q, irq_pin_out_q}, {30'h0, e});
   endtask
   task automatic pulse(input logic [31:0] s);
      @(posedge sys_clk);
      int_src_set <= s;
      @(posedge sys_clk);
      int_src_set <= 32'h0;
      repeat (3) @(posedge sys_clk);
   endtask
   // main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      pin_is(2'b01);
      for (t = 0; t < 4; t++) rchk(ofs[t], 32'hFFFF_FFFF, 32'h0);
      host.wr(8'h50, 32'h0);
      rchk(8'h50, 32'hFFFF_FFFF, ID);
      $display("test reset done");
      host.wr(8'h5C, 32'h0002_0001);
      host.wr(8'h54, 32'h0000_0111);
      pin_is(2'b10);
      pulse(32'h1);
      pin_is(2'b11);
      host.wr(8'h54, 32'h0000_0011);
      pin_is(2'b10);
      rchk(8'h58, 32'h1, 32'h1);
      rchk(8'h54, 32'h1000, 32'h1000);
      host.wr(8'h54, 32'h0000_0101);
      pin_is(2'b10);
      host.wr(8'h54, 32'h0000_0110);
      pin_is(2'b10);
      host.wr(8'h58, 32'h1);
      chk({31'h0, irq_pin_oe_q}, 32'h0);
      rchk(8'h54, 32'h1000, 32'h0);
      $display("test pin done");
      host.wr(8'h54, 32'h1000_0111);
      pulse(32'h1);
      pin_is(2'b11);
      host.wr(8'h58, 32'h1);
      pin_is(2'b10);
      pulse(32'h1);
      pin_is(2'b10);
      rchk(8'h54, 32'h2000, 32'h2000);
      pulse(32'h0002_0000);
      pin_is(2'b11);
      host.wr(8'h58, 32'h0002_0000);
      pin_is(2'b10);
      host.wr(8'h54, 32'h0000_0111);
      pin_is(2'b11);
      rchk(8'h54, 32'h2000, 32'h0);
      host.wr(8'h54, 32'h1000_4111);
      pin_is(2'b10);
      for (n = 0; irq_pin_out_q !== 1'b1 && n < 200; n++) @(posedge sys_clk);
      chk({31'h0, n >= 50 && n <= 66}, 32'h1);
      rchk(8'h54, 32'h4000, 32'h0);
      $display("test holdoff done");
      @(posedge sys_clk);
      soft_rst <= 1'b1;
      @(posedge sys_clk);
      soft_rst <= 1'b0;
      rchk(8'h54, 32'hFFFF_FFFF, 32'h0000_0011);
      rchk(8'h58, 32'hFFFF_FFFF, 32'h0);
      pin_is(2'b10);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rchk(8'h54, 32'hFFFF_FFFF, 32'h0);
      $display("test soft reset done");
      results();
   end
   // watchdog
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      results();
   end
endmodule
`default_nettype wire
